// ### rec_framer_pkg.sv
// Shared constants, register map and types for the recording packet framer
package rec_framer_pkg;
    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5; // 200 MHz system clock
    localparam int RTC_PERIOD_NS = 100; // 10 MHz relative count period
    localparam int RTC_TICK_CYCLES = RTC_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [7:0] EXT_STEP_NS = 8'(CLK_PERIOD_NS); // 5 ns counter step per clock
    localparam int EXT_PER_RTC = 100; // Extended counts per relative count
    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] REG_CONTROL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_RTC_LOW = 8'h08;
    localparam logic [7:0] REG_CHK_COUNT = 8'h0C;
    localparam logic [7:0] REG_CHAN_BASE = 8'h10;
    // Control fields
    localparam int CTL_RECORD = 0;
    localparam int CTL_FMT_LSB = 2;
    localparam logic [31:0] CONTROL_RESET = 32'h00000000;
    // Channel configuration fields
    localparam int CH_SUM_LSB = 0;
    localparam int CH_INTRA_PACKET_TIME_STAMP_SRC = 6;
    localparam int CH_SEC_EN = 7;
    localparam int CH_INTRA_PACKET_DATA_HEADER = 8;
    localparam logic [8:0] CHAN_RESET = 9'h000;
    // ------------------------------------------------------------------
    // Packet flags bit positions
    // ------------------------------------------------------------------
    localparam int FLAG_SEC = 7;
    localparam int FLAG_SRC = 6;
    localparam int FLAG_SYNC = 5;
    localparam int FLAG_OVF = 4;
    localparam int FLAG_FMT_LSB = 2;
    // Header geometry in 16-bit words
    localparam int PRI_WORDS = 12;
    localparam int SEC_WORDS = 6;
    localparam int LEAD_WORDS = 6;
    localparam logic [7:0] SEQ_RESET = 8'h00;
    // ------------------------------------------------------------------
    // Secondary time formats
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        FMT_WEIGHTED = 2'b00,
        FMT_PRECISION = 2'b01,
        FMT_EXTENDED = 2'b10,
        FMT_RESERVED = 2'b11
    } time_fmt_t;
    // Framer sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SUM = 2'b01,
        ST_SEND = 2'b10,
        ST_BODY = 2'b11
    } frame_state_t;
endpackage

// ### rec_time_base.sv
// Shared 10 MHz relative counter and 1 ns extended counter
`timescale 1ns/1ps
module rec_time_base
    import rec_framer_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Counters
    output logic [47:0] relative_count,
    output logic [63:0] extended_relative_count
);
    import rec_framer_pkg::*;

    // ------------------------------------------------------------------
    // Tick divider
    // ------------------------------------------------------------------
    logic [7:0] tick_div; // Cycles into the current 100 ns period
    wire tick_now = (tick_div == 8'(RTC_TICK_CYCLES - 1));

    // Divider wraps every 100 ns; never stops while out of reset
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            tick_div <= 8'h00;
        else if (tick_now)
            tick_div <= 8'h00;
        else
            tick_div <= tick_div + 8'h01;
    end

    // Only relative uses the divider; extended steps 5 every clock, so relative = extended / 100 holds
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            relative_count <= 48'h000000000000;
            extended_relative_count <= 64'h0000000000000000;
        end
        else
        begin
            extended_relative_count <= extended_relative_count + 64'(EXT_STEP_NS);
            if (tick_now)
                relative_count <= relative_count + 48'h000000000001;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_rtc_ext_ratio: assert property (@(posedge clock) disable iff (!rst_n)
        tick_now |=> (extended_relative_count / EXT_PER_RTC) == 64'(relative_count))
        else $error("relative count out of step with extended count");
    a_rtc_free_run: assert property (@(posedge clock) disable iff (!rst_n)
        tick_now |=> relative_count == $past(relative_count) + 48'h000000000001)
        else $error("relative count failed to advance");
endmodule

// ### rec_packet_framer.sv
// Recording packet header framer: sequence, flags, time, checksums, reader check
`timescale 1ns/1ps
module rec_packet_framer
    import rec_framer_pkg::*;
#(
    parameter int NUM_CH = 4
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    // Packet request, asserted at the first bit of body data
    input wire logic pkt_req,
    output logic pkt_ready,
    input wire logic [$clog2(NUM_CH)-1:0] pkt_channel,
    input wire logic [7:0] pkt_data_type,
    input wire logic pkt_overflow,
    input wire logic [LEAD_WORDS*16-1:0] pkt_lead_words,
    input wire logic [7:0] pkt_type_version,
    input wire logic [63:0] user_time,
    // Sync error pin from the timing receiver
    input wire logic rtc_sync_error_pin,
    // Header word stream
    output logic hdr_valid,
    input wire logic hdr_ready,
    output logic [15:0] hdr_word,
    output logic hdr_last,
    output logic csd_slot,
    // Intra-packet time stamp
    input wire logic [$clog2(NUM_CH)-1:0] stamp_channel,
    output logic [63:0] intra_packet_time_stamp,
    // Reader-side header check
    input wire logic chk_valid,
    input wire logic [15:0] chk_word,
    input wire logic chk_last,
    output logic chk_done,
    output logic chk_good
);
    import rec_framer_pkg::*;
    localparam int CW = $clog2(NUM_CH);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    // Wrapping 16-bit sum of the first n words of a header image
    function automatic logic [15:0] word_sum(input logic [15:0] w [0:PRI_WORDS-1], input int n);
        logic [15:0] s;
        s = 16'h0000;
        for (int i = 0; i < PRI_WORDS; i++)
            if (i < n)
                s = s + w[i];
        return s;
    endfunction

    // Assigned data type codes; everything else is held for growth
    function automatic logic type_assigned(input logic [7:0] t);
        case (t)
            8'h00, 8'h01, 8'h02, 8'h03, 8'h09, 8'h11, 8'h19, 8'h1A, 8'h21, 8'h29,
            8'h30, 8'h38, 8'h40, 8'h41, 8'h42, 8'h48, 8'h49, 8'h4A, 8'h50, 8'h58,
            8'h59, 8'h60, 8'h68, 8'h69, 8'h70, 8'h71, 8'h72, 8'h78: return 1'b1;
            default: return 1'b0;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Time base and sync error input
    // ------------------------------------------------------------------
    logic [47:0] relative_count; // Shared 10 MHz count
    logic [63:0] extended_relative_count; // Shared 1 ns count
    logic sync_meta; // First synchroniser stage
    logic sync_err; // Second stage, safe to use

    rec_time_base u_time_base (
        .clock(clock),
        .rst_n(rst_n),
        .relative_count(relative_count),
        .extended_relative_count(extended_relative_count)
    );

    // Pin comes from another domain, so two flops before use
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            sync_meta <= 1'b0;
            sync_err <= 1'b0;
        end
        else
        begin
            sync_meta <= rtc_sync_error_pin;
            sync_err <= sync_meta;
        end
    end

    // ------------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------------
    logic [31:0] control; // Record enable and shared time format
    logic [8:0] chan_cfg [0:NUM_CH-1]; // Per-channel options
    logic [7:0] seq [0:NUM_CH-1]; // Per-channel sequence counters
    logic [15:0] refused_count; // Requests with a reserved data type
    logic [15:0] chk_bad_count; // Reader checks that failed
    logic bus_ack; // One wait state on every access
    wire recording = control[CTL_RECORD];
    wire time_fmt_t fmt = time_fmt_t'(control[CTL_FMT_LSB +: 2]);
    // A write lands only at the edge where waitrequest is low
    wire wr_go = write & bus_ack;
    wire chan_hit = (address >= REG_CHAN_BASE) && (address < REG_CHAN_BASE + 8'(4 * NUM_CH));
    wire [CW-1:0] chan_idx = CW'((address - REG_CHAN_BASE) >> 2);

    assign waitrequest = (read | write) & ~bus_ack;

    // Acknowledge strobe: one cycle after the request arrives
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            bus_ack <= 1'b0;
        else
            bus_ack <= (read | write) & ~bus_ack;
    end

    // Control writes; the reserved format code is refused, keeping the old one
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            control <= CONTROL_RESET;
        else if (wr_go && address == REG_CONTROL)
        begin
            control[CTL_RECORD] <= writedata[CTL_RECORD];
            if (writedata[CTL_FMT_LSB +: 2] != FMT_RESERVED)
                control[CTL_FMT_LSB +: 2] <= writedata[CTL_FMT_LSB +: 2];
        end
    end

    // Channel options; data header presence is frozen while recording
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_CH; i++)
                chan_cfg[i] <= CHAN_RESET;
        end
        else if (wr_go && chan_hit)
        begin
            chan_cfg[chan_idx][CH_SEC_EN:0] <= writedata[CH_SEC_EN:0];
            if (!recording)
                chan_cfg[chan_idx][CH_INTRA_PACKET_DATA_HEADER] <= writedata[CH_INTRA_PACKET_DATA_HEADER];
        end
    end

    // Read data, registered at the acknowledge
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            readdata <= 32'h00000000;
        else if (read && !bus_ack)
        begin
            if (address == REG_CONTROL)
                readdata <= control;
            else if (address == REG_STATUS)
                readdata <= {16'h0000, refused_count};
            else if (address == REG_RTC_LOW)
                readdata <= relative_count[31:0];
            else if (address == REG_CHK_COUNT)
                readdata <= {16'h0000, chk_bad_count};
            else if (chan_hit)
                readdata <= {15'h0000, seq[chan_idx], chan_cfg[chan_idx]};
            else
                readdata <= 32'h00000000; // Unmapped reads return zero
        end
    end

    // ------------------------------------------------------------------
    // Header assembly
    // ------------------------------------------------------------------
    frame_state_t state; // Sequencer state
    logic [15:0] hdr [0:PRI_WORDS-1]; // Primary header image
    logic [15:0] sec [0:PRI_WORDS-1]; // Secondary header image, 6 words used
    logic [4:0] word_idx; // Word being offered
    logic with_sec; // Packet carries a secondary header
    logic [CW-1:0] cur_ch; // Channel of the packet in flight
    wire [8:0] cfg_req = chan_cfg[pkt_channel];
    wire [7:0] next_flags = {cfg_req[CH_SEC_EN],
                             cfg_req[CH_INTRA_PACKET_TIME_STAMP_SRC] & cfg_req[CH_SEC_EN],
                             sync_err,
                             pkt_overflow,
                             control[CTL_FMT_LSB +: 2],
                             cfg_req[CH_SUM_LSB +: 2]};
    // Secondary time: lower long word goes out first in every format
    wire [63:0] sec_time = (fmt == FMT_EXTENDED) ? extended_relative_count :
                           (fmt == FMT_WEIGHTED) ? {user_time[63:2], 2'b00} :
                           user_time;
    wire accept = pkt_req & pkt_ready;
    wire [4:0] last_idx = with_sec ? 5'(PRI_WORDS + SEC_WORDS - 1) : 5'(PRI_WORDS - 1);
    wire step = hdr_valid & hdr_ready;

    assign pkt_ready = (state == ST_IDLE) && recording && type_assigned(pkt_data_type);
    assign hdr_valid = (state == ST_SEND);
    assign hdr_last = hdr_valid && (word_idx == last_idx);
    assign csd_slot = (state == ST_BODY);

    // Word mux: primary words, then secondary words
    always_comb
    begin
        if (word_idx < 5'(PRI_WORDS))
            hdr_word = hdr[word_idx[3:0]];
        else
            hdr_word = sec[4'(word_idx - 5'(PRI_WORDS))];
    end

    // Sequencer: capture, checksum, send, then one body slot
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            word_idx <= 5'h00;
        end
        else
        begin
            case (state)
                ST_IDLE:
                    if (accept)
                        state <= ST_SUM;
                ST_SUM:
                begin
                    state <= ST_SEND;
                    word_idx <= 5'h00;
                end
                ST_SEND:
                    if (step && hdr_last)
                        state <= ST_BODY;
                    else if (step)
                        word_idx <= word_idx + 5'h01;
                ST_BODY:
                    state <= ST_IDLE;
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    // Header image: fields captured at the body's first bit, checksums after
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            with_sec <= 1'b0;
            cur_ch <= '0;
            for (int i = 0; i < PRI_WORDS; i++)
            begin
                hdr[i] <= 16'h0000;
                sec[i] <= 16'h0000;
            end
        end
        else if (accept)
        begin
            with_sec <= cfg_req[CH_SEC_EN];
            cur_ch <= pkt_channel;
            for (int i = 0; i < LEAD_WORDS; i++)
                hdr[i] <= pkt_lead_words[i*16 +: 16];
            hdr[6] <= {seq[pkt_channel], pkt_type_version};
            hdr[7] <= {pkt_data_type, next_flags};
            hdr[8] <= relative_count[15:0];
            hdr[9] <= relative_count[31:16];
            hdr[10] <= relative_count[47:32];
            for (int i = 0; i < 4; i++)
                sec[i] <= sec_time[i*16 +: 16];
            sec[4] <= 16'h0000;
        end
        else if (state == ST_SUM)
        begin
            hdr[PRI_WORDS-1] <= word_sum(hdr, PRI_WORDS - 1);
            sec[5] <= word_sum(sec, 5);
        end
    end

    // Sequence counters advance once per emitted packet and wrap at 8 bits
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_CH; i++)
                seq[i] <= SEQ_RESET;
        end
        else if (step && hdr_last)
            seq[cur_ch] <= seq[cur_ch] + 8'h01;
    end

    // Refused requests: reserved type offered while the framer is free
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            refused_count <= 16'h0000;
        else if (pkt_req && state == ST_IDLE && recording && !type_assigned(pkt_data_type))
            refused_count <= refused_count + 16'h0001;
    end

    // ------------------------------------------------------------------
    // Intra-packet time stamp
    // ------------------------------------------------------------------
    // Registered every cycle so the stamp follows the counter live
    always_ff @(posedge clock)
    begin
        if (!rst_n)
            intra_packet_time_stamp <= 64'h0000000000000000;
        else if (chan_cfg[stamp_channel][CH_INTRA_PACKET_TIME_STAMP_SRC] && chan_cfg[stamp_channel][CH_SEC_EN])
            intra_packet_time_stamp <= sec_time;
        else
            intra_packet_time_stamp <= {16'h0000, relative_count};
    end

    // ------------------------------------------------------------------
    // Reader-side header check
    // ------------------------------------------------------------------
    logic [15:0] chk_sum; // Running sum of words before the checksum
    wire chk_match = (chk_sum == chk_word);

    // Sum until the last word, which is the received checksum
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            chk_sum <= 16'h0000;
            chk_done <= 1'b0;
            chk_good <= 1'b0;
            chk_bad_count <= 16'h0000;
        end
        else
        begin
            chk_done <= chk_valid & chk_last;
            if (chk_valid && chk_last)
            begin
                chk_sum <= 16'h0000;
                chk_good <= chk_match;
                if (!chk_match)
                    chk_bad_count <= chk_bad_count + 16'h0001;
            end
            else if (chk_valid)
                chk_sum <= chk_sum + chk_word;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_seq_advance: assert property (@(posedge clock) disable iff (!rst_n)
        (step && hdr_last) |=> seq[$past(cur_ch)] == $past(seq[cur_ch]) + 8'h01)
        else $error("sequence did not advance by one");
    a_seq_wrap: assert property (@(posedge clock) disable iff (!rst_n)
        (step && hdr_last && seq[cur_ch] == 8'hFF) |=> seq[$past(cur_ch)] == 8'h00)
        else $error("sequence did not wrap to zero");
    a_flag_src_sec: assert property (@(posedge clock) disable iff (!rst_n)
        (state == ST_SEND && word_idx == 5'd7) |-> (!hdr_word[FLAG_SRC] || hdr_word[FLAG_SEC]))
        else $error("stamp source set without secondary header");
    a_flag_sec_len: assert property (@(posedge clock) disable iff (!rst_n)
        hdr_last |-> (hdr[7][FLAG_SEC] == (word_idx == 5'(PRI_WORDS + SEC_WORDS - 1))))
        else $error("secondary flag disagrees with header length");
    a_fmt_reserved: assert property (@(posedge clock) disable iff (!rst_n)
        control[CTL_FMT_LSB +: 2] != FMT_RESERVED)
        else $error("reserved time format held");
    a_type_legal: assert property (@(posedge clock) disable iff (!rst_n)
        accept |-> type_assigned(pkt_data_type))
        else $error("reserved data type accepted");
    a_hdr_sum: assert property (@(posedge clock) disable iff (!rst_n)
        (state == ST_SUM) |=> hdr[PRI_WORDS-1] == word_sum(hdr, PRI_WORDS - 1))
        else $error("header checksum wrong");
    a_sec_zero: assert property (@(posedge clock) disable iff (!rst_n)
        (hdr_valid && word_idx == 5'(PRI_WORDS + 4)) |-> hdr_word == 16'h0000)
        else $error("secondary reserved word not zero");
    a_time_capture: assert property (@(posedge clock) disable iff (!rst_n)
        accept |=> hdr[8] == $past(relative_count[15:0]))
        else $error("header time not sampled at request");
    a_body_once: assert property (@(posedge clock) disable iff (!rst_n)
        (step && hdr_last) |=> csd_slot ##1 (!csd_slot && state == ST_IDLE))
        else $error("channel-specific slot not exactly once");
    c_plain_pkt: cover property (@(posedge clock) hdr_last && !with_sec);
    c_sec_pkt: cover property (@(posedge clock) hdr_last && with_sec);
    c_stall: cover property (@(posedge clock) hdr_valid && !hdr_ready);
    c_chk_bad: cover property (@(posedge clock) chk_valid && chk_last && !chk_match);
endmodule

// ### rec_store_model.sv
// Recording store model that takes header words, with optional stalling
`timescale 1ns/1ps
module rec_store_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Header stream
    input wire logic hdr_valid,
    output logic hdr_ready,
    input wire logic [15:0] hdr_word,
    input wire logic hdr_last,
    // Stall control and captured packet
    input wire logic stall,
    output logic [15:0] words [0:17],
    output logic [4:0] count
);
    logic [4:0] idx; // Next word slot
    // Ready toggles while stalling, so the framer must hold each word
    always_ff @(posedge clock)
    begin
        if (!rst_n)
        begin
            hdr_ready <= 1'b0;
            idx <= 5'h00;
            count <= 5'h00;
        end
        else
        begin
            hdr_ready <= stall ? !hdr_ready : 1'b1;
            if (hdr_valid && hdr_ready)
            begin
                words[idx] <= hdr_word;
                idx <= hdr_last ? 5'h00 : idx + 5'h01;
                if (hdr_last) count <= idx + 5'h01;
            end
        end
    end
endmodule

// ### recorder_packet_header_framer_bench.sv
// Self-checking bench for the recording packet framer
`timescale 1ns/1ps
module recorder_packet_header_framer_bench;
    import rec_framer_pkg::*;
    // ----
    // Signals
    // ----
    logic clock = 1'b0, rst_n = 1'b0, read = 1'b0, write = 1'b0, pkt_req = 1'b0;
    logic pkt_overflow = 1'b0, rtc_sync_error_pin = 1'b0, chk_valid = 1'b0, chk_last = 1'b0;
    logic stall = 1'b0;
    logic [7:0] address = 8'h00, pkt_data_type = 8'h01, pkt_type_version = 8'h06;
    logic [31:0] writedata = 32'h0, readdata, q;
    logic [1:0] pkt_channel = 2'b00, stamp_channel = 2'b00;
    logic [15:0] chk_word = 16'h0000, hdr_word;
    logic [95:0] pkt_lead_words = 96'h0006_0005_0004_0003_0002_0001;
    logic [63:0] user_time = 64'h1122_3344_5566_778B, intra_packet_time_stamp;
    logic waitrequest, pkt_ready, hdr_valid, hdr_ready, hdr_last, csd_slot, chk_done, chk_good;
    logic [15:0] words [0:17];
    logic [4:0] count;
    int mismatches = 0, cmp_count = 0, k, i, j;
    // Rows: format, channel setup, overflow, sync error, flags, first time word
    typedef struct packed {logic [1:0] fmt; logic [8:0] cfg; logic ovf, syn;
        logic [7:0] flags; logic [15:0] w12;} row_t;
    row_t rows [4] = '{'{2'b00, 9'h080, 1'b0, 1'b0, 8'h80, 16'h7788},
        '{2'b10, 9'h081, 1'b1, 1'b0, 8'h99, 16'h0000},
        '{2'b01, 9'h0C2, 1'b0, 1'b1, 8'hE6, 16'h778B},
        '{2'b00, 9'h043, 1'b0, 1'b0, 8'h03, 16'h0000}};
    always #2.5 clock = ~clock;
    rec_packet_framer #(.NUM_CH(4)) i_rec_packet_framer (.*);
    rec_store_model i_rec_store_model (.*);
    // ----
    // Tasks
    // ----
    task complete_run;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Bounded wait: sel 0 bus answer, 1 packet ready, 2 body slot; looked at
    // mid-cycle where settled, returns just after the edge that samples it
    task edge_wait(input int sel, input int lim);
        k = 0;
        @(negedge clock);
        while (k < lim && !(sel == 0 ? !waitrequest : sel == 1 ? pkt_ready : csd_slot))
        begin
            @(negedge clock);
            k++;
        end
        if (k >= lim) check(32'h0, 32'h1);
        if (k >= lim) complete_run();
        @(posedge clock);
    endtask
    // Avalon access: held until waitrequest is seen low
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        @(posedge clock);
        edge_wait(0, 50);
        q = readdata;
        read <= 1'b0;
        write <= 1'b0;
        @(posedge clock);
    endtask
    // One packet request, then wait for the channel data slot
    task send(input logic [1:0] ch, input logic ovf, input logic syn);
        pkt_channel <= ch;
        pkt_overflow <= ovf;
        rtc_sync_error_pin <= syn;
        repeat (4) @(posedge clock);
        pkt_req <= 1'b1;
        edge_wait(1, 50);
        pkt_req <= 1'b0;
        @(posedge clock);
        edge_wait(2, 300);
    endtask
    function automatic logic [15:0] wsum(input int lo, input int hi);
        wsum = 16'h0000;
        for (int n = lo; n <= hi; n++) wsum += words[n];
    endfunction
    // ----
    // Sequence
    // ----
    initial
    begin
        repeat (3) @(posedge clock);
        rst_n <= 1'b1;
        bus(1'b0, 8'h10, 32'h0);
        check(q[16:9], 32'h0);
        for (i = 0; i < 4; i++)
        begin
            stall <= i[0];
            bus(1'b1, 8'h00, {28'h0, rows[i].fmt, 2'b01});
            bus(1'b1, 8'h10 + 8'(4 * i), {23'h0, rows[i].cfg});
            send(2'(i), rows[i].ovf, rows[i].syn);
            check(words[7], {24'h01, rows[i].flags});
            check(words[6], 32'h0006);
            check(words[11], wsum(0, 10));
            check(count, rows[i].cfg[7] ? 32'd18 : 32'd12);
            if (rows[i].cfg[7]) check({words[16], words[17]}, {16'h0, wsum(12, 16)});
            if (rows[i].cfg[7] && rows[i].fmt != 2'b10) check(words[12], rows[i].w12);
            if (rows[i].cfg[7] && rows[i].fmt != 2'b10) check(words[15], 32'h1122);
        end
        // Sequence wrap on channel 0 after it reaches its maximum
        for (j = 0; j < 254; j++) send(2'b00, 1'b0, 1'b0);
        send(2'b00, 1'b0, 1'b0);
        check(words[6][15:8], 32'hFF);
        send(2'b00, 1'b0, 1'b0);
        check(words[6][15:8], 32'h00);
        // Reserved data type is never accepted
        pkt_data_type <= 8'h04;
        repeat (3) @(posedge clock);
        check(pkt_ready, 32'h0);
        pkt_data_type <= 8'h01;
        // Reserved time format code keeps the old one
        bus(1'b1, 8'h00, 32'h0000000D);
        bus(1'b0, 8'h00, 32'h0);
        check(q[3:2], 32'h0);
        // Data header presence is frozen while recording
        bus(1'b1, 8'h10, 32'h00000180);
        bus(1'b0, 8'h10, 32'h0);
        check(q[8], 32'h0);
        // Stamps: relative count with zero top, then weighted secondary time
        stamp_channel <= 2'b00;
        repeat (2) @(posedge clock);
        check(intra_packet_time_stamp[63:48], 32'h0);
        stamp_channel <= 2'b10;
        repeat (2) @(posedge clock);
        check(intra_packet_time_stamp[31:0], 32'h55667788);
        // Reader check with a good and a bad checksum
        for (i = 0; i < 2; i++)
        begin
            for (j = 1; j <= 12; j++)
            begin
                chk_valid <= 1'b1;
                chk_word <= (j == 12) ? 16'h0042 + 16'(i) : 16'(j);
                chk_last <= (j == 12);
                @(posedge clock);
            end
            chk_valid <= 1'b0;
            chk_last <= 1'b0;
            @(negedge clock);
            check({chk_done, chk_good}, {30'h0, 1'b1, i == 0});
            @(posedge clock);
        end
        complete_run();
    end
endmodule
